// ==== verilog/pws_slave.sv ====
// Slave end of a pulse-width coded single-wire programming link.
// Assumes the register file answers i_rd_data combinationally from o_rd_addr
// and applies o_wr_en writes; lock straps are steady around reset.
`timescale 1ns/10ps

module pws_slave #(
    parameter int CNT_W = 18,
    parameter int MIN_PER_CYC = pws_pkg::RX_MIN_PER_CYC,
    parameter int MAX_PER_CYC = pws_pkg::RX_MAX_PER_CYC,
    parameter int TX_SYM_CYC = pws_pkg::TX_SYM_CYC
)(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_supply_sense_input,
    input wire logic i_lock_ro,
    input wire logic i_lock_off,
    input wire logic [7:0] i_rd_data,
    output logic o_led_sink,
    output logic o_wr_en,
    output logic [6:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic [6:0] o_rd_addr,
    output logic o_tx_busy,
    output logic o_lock_ro_req,
    output logic o_lock_off_req
);

    // ****************************************************************
    // Derived counts
    // ****************************************************************
    localparam logic [CNT_W-1:0] MIN_PER = CNT_W'(MIN_PER_CYC);
    localparam logic [CNT_W-1:0] MAX_PER = CNT_W'(MAX_PER_CYC);
    localparam logic [CNT_W-1:0] SYM_LAST = CNT_W'(TX_SYM_CYC - 1);
    localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(pws_pkg::TURN_CYC + TX_SYM_CYC - 1);
    localparam logic [CNT_W-1:0] ZERO_HI = CNT_W'(TX_SYM_CYC / 4);
    localparam logic [CNT_W-1:0] IDLE_HI = CNT_W'(TX_SYM_CYC / 2);
    localparam logic [CNT_W-1:0] ONE_HI = CNT_W'((TX_SYM_CYC * 3) / 4);
    localparam logic [2:0] BIT_LAST = 3'(pws_pkg::BYTE_BITS - 1);
    localparam logic [2:0] HDR_LAST = 3'(pws_pkg::HDR_BITS - 1);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        pws_pkg::pws_state_t st;
        logic sync1;
        logic sync2;
        logic prev;
        logic have_rise;
        logic [CNT_W-1:0] per_cnt;
        logic [CNT_W-1:0] hi_cnt;
        logic [2:0] bit_cnt;
        logic [7:0] shreg;
        logic [6:0] ptr;
        logic [3:0] wr_bytes;
        logic [CNT_W-1:0] tmr;
        logic [6:0] tx_idx;
        logic [6:0] tx_total;
        logic [CNT_W-1:0] tx_hi;
        logic [7:0] tx_byte;
        logic led;
        logic tx_busy;
        logic wr_en;
        logic [6:0] wr_addr;
        logic [7:0] wr_data;
        logic [6:0] rd_addr;
        logic lock_ro;
        logic lock_off;
        logic lock_ro_req;
        logic lock_off_req;
    } pws_regs_t;

    pws_regs_t r_reg;
    pws_regs_t r_next;
    logic rise;
    pws_pkg::pws_sym_t sym;
    logic sym_bit;
    logic [7:0] frame_byte;
    logic rx_active;

    // ****************************************************************
    // Symbol classifier
    // ****************************************************************
    // High time is scaled by eight so that the thresholds at 1/8, 3/8,
    // 5/8 and 7/8 of the period need no division.
    function automatic pws_pkg::pws_sym_t classify(input logic [CNT_W-1:0] per,
                                                   input logic [CNT_W-1:0] hi);
        logic [CNT_W+2:0] p;
        logic [CNT_W+2:0] h8;
        pws_pkg::pws_sym_t s;
        p = (CNT_W+3)'(per);
        h8 = (CNT_W+3)'(hi) << 3;
        if (per < MIN_PER || per > MAX_PER)
            s = pws_pkg::SYM_BAD;
        else if (h8 < p || h8 > p * (CNT_W+3)'(7))
            s = pws_pkg::SYM_BAD;
        else if (h8 < p * (CNT_W+3)'(3))
            s = pws_pkg::SYM_ZERO;
        else if (h8 < p * (CNT_W+3)'(5))
            s = pws_pkg::SYM_IDLE;
        else
            s = pws_pkg::SYM_ONE;
        return s;
    endfunction

    assign rise = r_reg.sync2 & ~r_reg.prev;
    assign sym = classify(r_reg.per_cnt, r_reg.hi_cnt);
    assign sym_bit = (sym == pws_pkg::SYM_ONE);
    assign frame_byte = {r_reg.shreg[6:0], sym_bit};
    // Symbols count only once a full period has been seen and the link is enabled.
    assign rx_active = rise && r_reg.have_rise && !r_reg.lock_off;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        r_next = r_reg;
        r_next.wr_en = 1'b0;
        r_next.sync1 = i_supply_sense_input;
        r_next.sync2 = r_reg.sync1;
        r_next.prev = r_reg.sync2;

        if (r_reg.st != pws_pkg::ST_WAIT && r_reg.st != pws_pkg::ST_TX)
        begin
            if (rise)
            begin
                r_next.have_rise = 1'b1;
                r_next.per_cnt = CNT_W'(1);
                r_next.hi_cnt = CNT_W'(1);
            end
            else if (r_reg.have_rise)
            begin
                // A line parked beyond the slowest period drops the measurement.
                if (r_reg.per_cnt >= MAX_PER)
                begin
                    r_next.have_rise = 1'b0;
                    r_next.st = pws_pkg::ST_HUNT;
                end
                else
                begin
                    r_next.per_cnt = r_reg.per_cnt + CNT_W'(1);
                    r_next.hi_cnt = r_reg.hi_cnt + CNT_W'(r_reg.sync2);
                end
            end
        end

        if (rx_active)
        begin
            unique case (r_reg.st)
                pws_pkg::ST_HUNT:
                begin
                    if (sym == pws_pkg::SYM_IDLE)
                    begin
                        r_next.st = pws_pkg::ST_HDR;
                        r_next.bit_cnt = 3'h0;
                    end
                end
                pws_pkg::ST_HDR:
                begin
                    if (sym == pws_pkg::SYM_IDLE)
                        r_next.bit_cnt = 3'h0;
                    else if (sym == pws_pkg::SYM_BAD)
                        r_next.st = pws_pkg::ST_HUNT;
                    else
                    begin
                        r_next.shreg = frame_byte;
                        r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
                        if (r_reg.bit_cnt == HDR_LAST)
                        begin
                            if (frame_byte[7])
                            begin
                                // The edge ending the last address bit is the closing idle.
                                r_next.rd_addr = frame_byte[6:0];
                                r_next.st = pws_pkg::ST_WAIT;
                                r_next.tmr = '0;
                                r_next.have_rise = 1'b0;
                            end
                            else
                            begin
                                r_next.ptr = frame_byte[6:0];
                                r_next.wr_bytes = 4'h0;
                                r_next.bit_cnt = 3'h0;
                                r_next.st = pws_pkg::ST_DATA;
                            end
                        end
                    end
                end
                pws_pkg::ST_DATA:
                begin
                    if (sym == pws_pkg::SYM_IDLE || sym == pws_pkg::SYM_BAD)
                        r_next.st = pws_pkg::ST_HUNT;
                    else
                    begin
                        r_next.shreg = frame_byte;
                        r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
                        if (r_reg.bit_cnt == BIT_LAST)
                        begin
                            if (r_reg.wr_bytes == pws_pkg::MAX_WR_BYTES)
                                r_next.st = pws_pkg::ST_HUNT;
                            else
                            begin
                                r_next.wr_en = !r_reg.lock_ro;
                                r_next.wr_addr = r_reg.ptr;
                                r_next.wr_data = frame_byte;
                                r_next.ptr = r_reg.ptr + 7'h1;
                                r_next.wr_bytes = r_reg.wr_bytes + 4'h1;
                                if (!r_reg.lock_ro && r_reg.ptr == pws_pkg::LOCK_ADDR)
                                begin
                                    if (frame_byte == pws_pkg::LOCK_RO_VAL)
                                        r_next.lock_ro_req = 1'b1;
                                    if (frame_byte == pws_pkg::LOCK_OFF_VAL)
                                        r_next.lock_off_req = 1'b1;
                                end
                            end
                        end
                    end
                end
                pws_pkg::ST_WAIT, pws_pkg::ST_TX: ;
            endcase
        end

        // Turnaround: input is ignored from the closing edge onward.
        if (r_reg.st == pws_pkg::ST_WAIT)
        begin
            if (r_reg.tmr == WAIT_LAST)
            begin
                r_next.st = pws_pkg::ST_TX;
                r_next.tmr = '0;
                r_next.tx_idx = 7'h0;
                r_next.tx_total = (r_reg.rd_addr == pws_pkg::STATUS_ADDR) ?
                    pws_pkg::STATUS_TOTAL_SYMS : pws_pkg::RD_TOTAL_SYMS;
            end
            else
                r_next.tmr = r_reg.tmr + CNT_W'(1);
        end

        if (r_reg.st == pws_pkg::ST_TX)
        begin
            if (r_reg.tmr == '0)
            begin
                if (r_reg.tx_idx == 7'h0 || r_reg.tx_idx == r_reg.tx_total - 7'h1)
                    r_next.tx_hi = IDLE_HI;
                else if (r_reg.tx_idx[2:0] == 3'h1)
                begin
                    r_next.tx_hi = i_rd_data[7] ? ONE_HI : ZERO_HI;
                    r_next.tx_byte = {i_rd_data[6:0], 1'b0};
                    r_next.rd_addr = r_reg.rd_addr + 7'h1;
                end
                else
                begin
                    r_next.tx_hi = r_reg.tx_byte[7] ? ONE_HI : ZERO_HI;
                    r_next.tx_byte = {r_reg.tx_byte[6:0], 1'b0};
                end
            end
            if (r_reg.tmr == SYM_LAST)
            begin
                r_next.tmr = '0;
                if (r_reg.tx_idx == r_reg.tx_total - 7'h1)
                begin
                    r_next.st = pws_pkg::ST_HUNT;
                    r_next.have_rise = 1'b0;
                end
                else
                    r_next.tx_idx = r_reg.tx_idx + 7'h1;
            end
            else
                r_next.tmr = r_reg.tmr + CNT_W'(1);
        end

        // The sink runs one cycle behind the symbol timer; the lag is uniform.
        r_next.led = (r_reg.st == pws_pkg::ST_TX) && (r_reg.tmr < r_next.tx_hi);
        r_next.tx_busy = (r_next.st == pws_pkg::ST_TX);

        if (i_rst)
        begin
            r_next = '0;
            r_next.st = pws_pkg::ST_HUNT;
            // Lock straps are taken at every reset; a new mode needs only a reset.
            r_next.lock_ro = i_lock_ro;
            r_next.lock_off = i_lock_off;
        end
    end

    always_ff @(posedge i_clk)
    begin
        r_reg <= r_next;
    end

    assign o_led_sink = r_reg.led;
    assign o_wr_en = r_reg.wr_en;
    assign o_wr_addr = r_reg.wr_addr;
    assign o_wr_data = r_reg.wr_data;
    assign o_rd_addr = r_reg.rd_addr;
    assign o_tx_busy = r_reg.tx_busy;
    assign o_lock_ro_req = r_reg.lock_ro_req;
    assign o_lock_off_req = r_reg.lock_off_req;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    chk_no_write_locked: assert property (o_wr_en |-> !r_reg.lock_ro && !r_reg.lock_off)
        else $error("Write strobe issued while writes are locked.");

    chk_off_no_reply: assert property (r_reg.lock_off |-> r_reg.st == pws_pkg::ST_HUNT)
        else $error("Frame activity while the link is disabled.");

    chk_led_only_tx: assert property (r_reg.st != pws_pkg::ST_TX |-> !o_led_sink)
        else $error("Indicator sink active outside a reply.");

    chk_no_write_tx: assert property (r_reg.st == pws_pkg::ST_TX |-> !o_wr_en)
        else $error("Write strobe during a reply.");

    chk_turn_wait: assert property ($rose(r_reg.st == pws_pkg::ST_TX) |->
        $past(r_reg.st) == pws_pkg::ST_WAIT && $past(r_reg.tmr) == WAIT_LAST)
        else $error("Reply began before the turnaround time.");

    chk_reply_length: assert property ($rose(r_reg.st == pws_pkg::ST_TX) |->
        r_reg.tx_total == ((r_reg.rd_addr == pws_pkg::STATUS_ADDR) ? 7'h0A : 7'h42))
        else $error("Reply length does not match the addressed register.");

    chk_reply_opens_high: assert property ($rose(r_reg.st == pws_pkg::ST_TX) |=>
        o_led_sink && r_reg.tx_hi == IDLE_HI)
        else $error("Reply did not open with an idle symbol.");

    chk_symbol_rate: assert property (r_reg.st == pws_pkg::ST_TX |-> r_reg.tmr <= SYM_LAST)
        else $error("Reply symbol longer than its fixed period.");

    chk_read_header: assert property (rx_active && r_reg.st == pws_pkg::ST_HDR &&
        r_reg.bit_cnt == HDR_LAST && (sym == pws_pkg::SYM_ZERO || sym_bit) && r_reg.shreg[6] |=>
        r_reg.st == pws_pkg::ST_WAIT && o_rd_addr == $past(frame_byte[6:0]))
        else $error("Read header did not start the turnaround.");

    chk_bad_abandons: assert property (rx_active && sym == pws_pkg::SYM_BAD &&
        r_reg.st != pws_pkg::ST_WAIT && r_reg.st != pws_pkg::ST_TX |=>
        r_reg.st == pws_pkg::ST_HUNT)
        else $error("Invalid symbol did not abandon the frame.");

    chk_write_addr_step: assert property (o_wr_en |-> r_reg.ptr == o_wr_addr + 7'h1 &&
        r_reg.wr_bytes <= pws_pkg::MAX_WR_BYTES)
        else $error("Write address did not advance by one.");

endmodule

// ==== shared/pws_pkg.sv ====
// Constants and types shared by the pulse-width single-wire slave.
// Assumes a 100 MHz device clock and a single synchronous reset.
package pws_pkg;

    // ****************************************************************
    // Clock and link timing
    // ****************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_MHZ = 100;
    localparam int RX_MIN_BPS = 1000;
    localparam int RX_MAX_BPS = 10000;
    localparam int TX_BPS = 7000;
    localparam int PER_SLACK_PCT = 25;
    localparam int PCT_FULL = 100;
    localparam int TURN_US = 10;
    localparam int TURN_CYC = TURN_US * CLK_MHZ;
    localparam int RX_MIN_PER_CYC = (CLK_HZ / RX_MAX_BPS) * (PCT_FULL - PER_SLACK_PCT) / PCT_FULL;
    localparam int RX_MAX_PER_CYC = (CLK_HZ / RX_MIN_BPS) * (PCT_FULL + PER_SLACK_PCT) / PCT_FULL;
    localparam int TX_SYM_CYC = CLK_HZ / TX_BPS;

    // ****************************************************************
    // Frame layout
    // ****************************************************************
    localparam int HDR_BITS = 8;
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] MAX_WR_BYTES = 4'h8;
    localparam logic [6:0] RD_TOTAL_SYMS = 7'h42;
    localparam logic [6:0] STATUS_TOTAL_SYMS = 7'h0A;
    localparam logic [6:0] STATUS_ADDR = 7'h7E;
    localparam logic [6:0] LOCK_ADDR = 7'h7F;
    localparam logic [7:0] LOCK_RO_VAL = 8'h40;
    localparam logic [7:0] LOCK_OFF_VAL = 8'h80;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {ST_HUNT, ST_HDR, ST_DATA, ST_WAIT, ST_TX} pws_state_t;
    typedef enum logic [1:0] {SYM_ZERO, SYM_ONE, SYM_IDLE, SYM_BAD} pws_sym_t;

endpackage

// ==== testbench/pws_master_model.sv ====
// Behavioural master that modulates the loop supply and decodes replies.
// Assumes one bench process calls its tasks and everything runs on i_clk.
`timescale 1ns/10ps
module pws_master_model #(
    parameter int TX_SYM = 40,
    parameter int GAP = 500
)(
    input wire logic i_clk,
    input wire logic i_led_sink,
    output logic o_line
);
    // Codes: 0 zero, 1 one, 2 idle, 3 malformed.
    logic [1:0] rx_q[$];
    int per_err;
    int cnt;
    int hc;
    int cyc;
    int mark;
    logic led_q;
    logic have;

    initial
    begin
        o_line = 1'b0;
        per_err = 0;
        cnt = 0;
        hc = 0;
        cyc = 0;
        mark = 0;
        led_q = 1'b0;
        have = 1'b0;
    end

    // ****************************************************************
    // Symbol transmission
    // ****************************************************************
    // The line rests low, at the plain loop supply level, between pulses.
    task automatic sym(input int k, input int per);
        int hi;
        hi = (k == 0) ? per / 4 : (k == 1) ? 3 * per / 4 : (k == 2) ? per / 2 : per / 16;
        @(posedge i_clk) o_line <= 1'b1;
        repeat (hi - 1) @(posedge i_clk);
        @(posedge i_clk) o_line <= 1'b0;
        repeat (per - hi - 1) @(posedge i_clk);
    endtask

    task automatic hdr(input logic dir, input logic [6:0] addr, input int per);
        sym(2, per);
        sym(int'(dir), per);
        for (int i = 6; i >= 0; i--) sym(int'(addr[i]), per);
    endtask

    // Silence longer than the drop time makes the next frame start afresh.
    task automatic release_line();
        @(posedge i_clk) o_line <= 1'b0;
        repeat (GAP) @(posedge i_clk);
    endtask

    task automatic wr_frame(input logic [6:0] addr, input logic [7:0] d[$], input int per);
        hdr(1'b0, addr, per);
        foreach (d[j])
            for (int i = 7; i >= 0; i--) sym(int'(d[j][i]), per);
        sym(2, per);
        @(posedge i_clk) o_line <= 1'b1;
        repeat (per / 2 - 1) @(posedge i_clk);
        release_line();
    endtask

    task automatic rd_req(input logic [6:0] addr, input int per, input logic hold);
        hdr(1'b1, addr, per);
        @(posedge i_clk) o_line <= 1'b1;
        mark = cyc;
        if (!hold)
        begin
            repeat (per / 2 - 1) @(posedge i_clk);
            @(posedge i_clk) o_line <= 1'b0;
        end
    endtask

    // ****************************************************************
    // Reply decoding
    // ****************************************************************
    function automatic logic [1:0] kind(input int h);
        return (h * 8 < 3 * TX_SYM) ? 2'h0 : (h * 8 < 5 * TX_SYM) ? 2'h2 : 2'h1;
    endfunction

    task automatic flush();
        if (have)
            rx_q.push_back(kind(hc));
        have = 1'b0;
    endtask

    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        led_q <= i_led_sink;
        if (i_led_sink === 1'b1 && led_q !== 1'b1)
        begin
            if (have)
                rx_q.push_back(kind(hc));
            if (have && cnt != TX_SYM)
                per_err++;
            have = 1'b1;
            cnt = 1;
            hc = 1;
        end
        else
        begin
            cnt++;
            if (i_led_sink === 1'b1)
                hc++;
        end
    end
endmodule

// ==== testbench/tb_pws_slave.sv ====
// Self-checking bench for the pulse-width single-wire slave.
// Assumes the master model drives the line and a patterned register file answers reads.
`timescale 1ns/10ps
module tb_pws_slave;
    localparam int TX_SYM = 40;
    localparam int LIMIT = 60000;
    logic i_clk;
    logic i_rst;
    logic i_lock_ro;
    logic i_lock_off;
    logic line;
    logic [7:0] rd_data;
    logic o_led_sink;
    logic o_wr_en;
    logic [6:0] o_wr_addr;
    logic [7:0] o_wr_data;
    logic [6:0] o_rd_addr;
    logic o_tx_busy;
    logic o_lock_ro_req;
    logic o_lock_off_req;
    int n_fail;
    int samples_checked;
    int cyc;
    logic [14:0] wr_q[$];

    // Short counts keep the run brief; the turnaround stays at its full length.
    pws_slave #(.CNT_W(18), .MIN_PER_CYC(20), .MAX_PER_CYC(400), .TX_SYM_CYC(TX_SYM)) i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_supply_sense_input(line), .i_lock_ro(i_lock_ro),
        .i_lock_off(i_lock_off), .i_rd_data(rd_data), .o_led_sink(o_led_sink),
        .o_wr_en(o_wr_en), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
        .o_rd_addr(o_rd_addr), .o_tx_busy(o_tx_busy), .o_lock_ro_req(o_lock_ro_req),
        .o_lock_off_req(o_lock_off_req));

    pws_master_model #(.TX_SYM(TX_SYM), .GAP(500)) i_master (
        .i_clk(i_clk), .i_led_sink(o_led_sink), .o_line(line));

    function automatic logic [7:0] regval(input logic [6:0] a);
        return {a, 1'b1} ^ 8'hC3;
    endfunction

    assign rd_data = regval(o_rd_addr);

    initial
    begin
        i_clk = 1'b0;
        i_rst = 1'b1;
        i_lock_ro = 1'b0;
        i_lock_off = 1'b0;
        n_fail = 0;
        samples_checked = 0;
        cyc = 0;
    end

    always #5 i_clk = ~i_clk;

    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (o_wr_en === 1'b1)
            wr_q.push_back({o_wr_addr, o_wr_data});
        if (cyc == LIMIT)
        begin
            n_fail++;
            finish_test();
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Straps are only taken while reset is held.
    task automatic do_reset(input logic ro, input logic off);
        @(posedge i_clk);
        i_rst <= 1'b1;
        i_lock_ro <= ro;
        i_lock_off <= off;
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        check({o_tx_busy, o_led_sink, o_lock_ro_req, o_lock_off_req}, 32'h0);
        wr_q.delete();
    endtask

    task automatic wr1(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] q[$];
        q = {v};
        i_master.wr_frame(a, q, 30);
    endtask

    // A byte count of zero means no reply may come at all.
    task automatic t_read(input logic [6:0] addr, input int nbytes, input logic hold);
        int n;
        logic [7:0] b;
        i_master.rx_q.delete();
        i_master.per_err = 0;
        i_master.rd_req(addr, 30, hold);
        n = 0;
        while (o_tx_busy !== 1'b1 && n < 1200)
        begin
            @(posedge i_clk);
            n++;
        end
        if (nbytes == 0)
        begin
            check({o_tx_busy, 31'h0} | i_master.rx_q.size(), 32'h0);
            i_master.release_line();
            return;
        end
        check((i_master.cyc - i_master.mark) inside {[1040:1050]}, 32'h1);
        n = 0;
        while (o_tx_busy === 1'b1 && n < 5000)
        begin
            @(posedge i_clk);
            n++;
        end
        i_master.flush();
        i_master.release_line();
        check(o_rd_addr, 7'(addr + nbytes));
        check(i_master.rx_q.size(), 2 + 8 * nbytes);
        check(i_master.per_err, 0);
        check(i_master.rx_q[0], 2);
        check(i_master.rx_q[1 + 8 * nbytes], 2);
        for (int i = 0; i < 8 * nbytes; i++)
        begin
            b = regval(7'(addr + i / 8));
            check(i_master.rx_q[i + 1], b[7 - i % 8]);
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_write_burst();
        logic [7:0] d[$];
        d = {8'h01, 8'h80, 8'hFF, 8'h00, 8'h5A, 8'hA5, 8'h3C, 8'hC3, 8'h77};
        i_master.wr_frame(7'h10, d, 30);
        check(wr_q.size(), 8);
        check({i_master.have, 31'h0} | i_master.rx_q.size(), 32'h0);
        for (int i = 0; i < 8; i++)
            check(wr_q[i], {7'(7'h10 + i), d[i]});
        wr_q.delete();
    endtask

    task automatic t_write_slow();
        logic [7:0] d[$];
        d = {8'h96, 8'h69};
        i_master.wr_frame(7'h20, d, 300);
        check(wr_q.size(), 2);
        check(wr_q[1], {7'h21, 8'h69});
        wr_q.delete();
    endtask

    task automatic t_bad_symbol();
        i_master.hdr(1'b0, 7'h30, 40);
        repeat (4) i_master.sym(1, 40);
        i_master.sym(3, 40);
        repeat (8) i_master.sym(1, 40);
        i_master.release_line();
        check(wr_q.size(), 0);
        wr1(7'h31, 8'h42);
        check(wr_q.size(), 1);
        check(wr_q[0], {7'h31, 8'h42});
        wr_q.delete();
    endtask

    task automatic t_lock_req();
        wr1(7'h7F, 8'h40);
        check({o_lock_ro_req, o_lock_off_req}, 32'h2);
        wr1(7'h7F, 8'h80);
        check({o_lock_ro_req, o_lock_off_req}, 32'h3);
    endtask

    task automatic t_lock_ro();
        wr1(7'h12, 8'h33);
        wr1(7'h7F, 8'h40);
        check(wr_q.size(), 0);
        check(o_lock_ro_req, 32'h0);
        t_read(7'h12, 8, 1'b0);
    endtask

    task automatic t_lock_off();
        wr1(7'h12, 8'h33);
        check(wr_q.size(), 0);
        t_read(7'h12, 0, 1'b1);
    endtask

    initial
    begin
        do_reset(1'b0, 1'b0);
        t_write_burst();
        t_write_slow();
        t_bad_symbol();
        t_read(7'h05, 8, 1'b1);
        t_read(7'h7E, 1, 1'b0);
        t_lock_req();
        do_reset(1'b1, 1'b0);
        t_lock_ro();
        do_reset(1'b0, 1'b1);
        t_lock_off();
        finish_test();
    end
endmodule
